// ==== src/srp_service_poll.sv ====
// Purpose: Status byte, service request and poll responses of a bus port
// Assumes: Commands and conditions come from logic on clk_i
// Notes: Poll state pins are synchronised before use
`timescale 1ns/1ns
`default_nettype none
`include "srp_params.svh"
//
// Overview of operation
// - Keep eight-bit status byte with fixed weights
// - Live status bits follow their conditions
// - Request-service flag set with every SRQ
// - Serial poll drives whole status byte
// - Data-ready bit while output data waits
// - End-of-file on store full or last read
// - Error bit only for status-affecting errors
// - Enable mask; first enabled event raises SRQ
// - One request disarms until new enable
// - Enable zero disarms and clears error
// - Abort disarms and clears error, end-of-file and request bits
// - Flag and error cleared by enable, abort, init
// - Poll line one to eight, zero disables
// - Sense selects parallel poll response polarity
// - Poll response follows SRQ event, cleared likewise
// - Poll line setting survives successive requests
// - Selectable line terminator, default CR LF
// - Separator comma or same as terminator
module srp_service_poll (
  input wire logic clk_i,                                    // Clock, 20 MHz
  input wire logic rst_i,                                    // Sync reset, power-off
  input wire logic ce_i,                                     // Clock enable
  input wire srp_pkg::srp_cond_t cond_i,                     // Live conditions
  input wire logic error_event_i,                            // Status error pulse
  input wire logic reading_stored_i,                         // Reading put in store
  input wire logic file_last_read_i,                         // Final reading read out
  input wire logic file_clear_i,                             // Store emptied
  input wire logic abort_i,                                  // Front-panel abort
  input wire logic init_i,                                   // Initialise
  input wire srp_pkg::srp_cmd8_t event_enable_command_i,     // Enable mask command
  input wire srp_pkg::srp_cmd4_t poll_line_select_command_i, // Poll line command
  input wire srp_pkg::srp_cmd1_t poll_sense_command_i,       // Poll sense command
  input wire srp_pkg::srp_cmd7_t store_size_cmd_i,           // Store size command
  input wire srp_pkg::srp_fmt_cmd_t format_cmd_i,            // Term and sep command
  input wire logic spoll_active_i,                           // Pin: being serial polled
  input wire logic ppoll_active_i,                           // Pin: parallel poll in progress
  input wire logic line_req_valid_i,                         // Line end request
  input wire logic line_req_term_i,                          // 1 terminator, 0 separator
  output logic line_req_ready_o,                             // Line end taken
  output logic tx_valid_o,                                   // Char valid
  input wire logic tx_ready_i,                               // Char taken
  output logic [7:0] tx_byte_o,                              // Char
  output logic tx_eoi_o,                                     // EOI with char
  output logic [7:0] service_status_byte_o,                  // Status byte
  output logic srq_o,                                        // SRQ level, always low
  output logic srq_oe_o,                                     // SRQ drive enable
  output logic [7:0] dio_o,                                  // Data lines, 1 = true
  output logic [7:0] dio_oe_o                                // Data line drive enables
);
  import srp_pkg::*;

  srp_state_t s;
  srp_state_t nxt;
  logic [1:0] sync_q;
  logic sp;
  logic pp;
  logic [7:0] live;
  logic [7:0] rise;
  logic fire;
  logic rel;

  // One-hot drive pattern for a poll line, none for zero
  function automatic logic [7:0] srp_line_dec(input logic [3:0] line);
    logic [7:0] v;
    v = 8'h00;
    if (line != `SRP_LINE_OFF && line <= `SRP_LINE_MAX) begin
      v = 8'h01 << (line - 4'h1);
    end
    return v;
  endfunction : srp_line_dec

  // Values after reset or initialise
  function automatic srp_state_t srp_init_st();
    srp_state_t v;
    v = '0;
    v.stb = `SRP_STB_RST;
    v.mask = `SRP_MASK_RST;
    v.pp_line = `SRP_LINE_RST;
    v.sense = `SRP_SENSE_RST;
    v.store = `SRP_STORE_RST;
    v.term = `SRP_TERM_RST;
    v.sep = `SRP_SEP_RST;
    return v;
  endfunction : srp_init_st

  // Poll state pins into the clock domain
  srp_sync2 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({spoll_active_i, ppoll_active_i}),
    .q_o(sync_q)
  );
  assign sp = sync_q[1];
  assign pp = sync_q[0];

  // Next-state logic
  always_comb begin
    nxt = s;
    live = 8'h00;
    rise = 8'h00;
    fire = 1'b0;
    rel = 1'b0;
    // Output format and store size selection
    if (format_cmd_i.vld) begin
      nxt.term = format_cmd_i.term;
      nxt.sep = format_cmd_i.sep;
    end
    if (store_size_cmd_i.vld) begin
      nxt.store = store_size_cmd_i.val;
    end
    // Parallel poll configuration, out of range ignored
    if (poll_line_select_command_i.vld && poll_line_select_command_i.val <= `SRP_LINE_MAX) begin
      nxt.pp_line = poll_line_select_command_i.val;
      if (poll_line_select_command_i.val == `SRP_LINE_OFF) begin
        nxt.pp_req = 1'b0;
      end
    end
    if (poll_sense_command_i.vld) begin
      nxt.sense = poll_sense_command_i.val;
    end
    // Reading store count
    if (file_clear_i) begin
      nxt.cnt = 7'h00;
      nxt.eof = 1'b0;
    end else if (reading_stored_i && s.cnt != s.store) begin
      nxt.cnt = s.cnt + 7'h01;
      if ((s.cnt + 7'h01) == s.store) begin
        nxt.eof = 1'b1;
      end
    end
    // Enable command arms or disarms
    if (event_enable_command_i.vld) begin
      nxt.mask = event_enable_command_i.val;
      nxt.armed = |event_enable_command_i.val;
      nxt.rqs = 1'b0;
      nxt.err = 1'b0;
      nxt.srq = 1'b0;
      nxt.pp_req = 1'b0;
      nxt.polled = 1'b0;
    end
    // Abort clears stored status and disarms
    if (abort_i) begin
      nxt.mask = `SRP_MASK_RST;
      nxt.armed = 1'b0;
      nxt.rqs = 1'b0;
      nxt.err = 1'b0;
      nxt.srq = 1'b0;
      nxt.pp_req = 1'b0;
      nxt.polled = 1'b0;
      nxt.eof = 1'b0;
      nxt.cnt = 7'h00;
    end
    // Last-read, error and request events win over enable, abort and file clears in the same cycle; init wins over events
    if (file_last_read_i) begin
      nxt.eof = 1'b1;
    end
    if (error_event_i) begin
      nxt.err = 1'b1;
    end
    // Serial poll completion releases SRQ
    nxt.sp_prev = sp;
    if (sp && !s.sp_prev) begin
      nxt.polled = s.srq;
    end
    rel = !sp && s.sp_prev && s.polled;
    if (rel) begin
      nxt.srq = 1'b0;
      nxt.polled = 1'b0;
    end
    // Live status byte without the request flag
    live[`SRP_BIT_DRDY] = cond_i.data_ready;
    live[`SRP_BIT_PROG] = cond_i.end_program;
    live[`SRP_BIT_FILE] = nxt.eof;
    live[`SRP_BIT_PLOT] = cond_i.end_plot;
    live[`SRP_BIT_SWEEP] = cond_i.end_sweep;
    live[`SRP_BIT_MEAS] = cond_i.end_measure;
    live[`SRP_BIT_ERR] = nxt.err;
    // First enabled rising condition raises one request
    rise = live & ~s.stb;
    fire = s.armed && (|(rise & s.mask));
    if (fire) begin
      nxt.srq = 1'b1;
      nxt.rqs = 1'b1;
      nxt.pp_req = 1'b1;
      if (!event_enable_command_i.vld) begin
        nxt.armed = 1'b0;
      end
    end
    if (init_i) begin
      nxt = srp_init_st();
    end
    nxt.stb = live;
    nxt.stb[`SRP_BIT_RQS] = nxt.rqs;
    if (init_i) begin
      nxt.stb = `SRP_STB_RST;
    end
    // Data line drive: parallel poll first, then serial poll
    nxt.dio = 8'h00;
    nxt.dio_oe = 8'h00;
    if (pp) begin
      if (s.pp_req == s.sense) begin
        nxt.dio = srp_line_dec(s.pp_line);
        nxt.dio_oe = srp_line_dec(s.pp_line);
      end
    end else if (sp) begin
      nxt.dio = nxt.stb;
      nxt.dio_oe = `SRP_DIO_ALL;
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= srp_init_st();
    end else if (ce_i) begin
      s <= nxt;
    end
  end

  // Terminator and separator characters
  srp_line_term u_term (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .term_i(s.term),
    .sep_i(s.sep),
    .req_valid_i(line_req_valid_i),
    .req_term_i(line_req_term_i),
    .req_ready_o(line_req_ready_o),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i),
    .tx_byte_o(tx_byte_o),
    .tx_eoi_o(tx_eoi_o)
  );

  // Outputs from state
  assign service_status_byte_o = s.stb;
  assign srq_o = 1'b0;
  assign srq_oe_o = s.srq;
  assign dio_o = s.dio;
  assign dio_oe_o = s.dio_oe;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rqs_srq;
    srq_oe_o |-> service_status_byte_o[`SRP_BIT_RQS];
  endproperty
  a_rqs_srq: assert property (p_rqs_srq) else $error("SRQ without request flag");

  property p_fire_srq;
    ce_i && fire && !init_i |=> srq_oe_o && service_status_byte_o[`SRP_BIT_RQS];
  endproperty
  a_fire_srq: assert property (p_fire_srq) else $error("Enabled event gave no SRQ");

  property p_disarm;
    ce_i && fire && !event_enable_command_i.vld |=> !s.armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("Still armed after request");

  property p_sv_zero;
    ce_i && event_enable_command_i.vld && event_enable_command_i.val == 8'h00
      && !error_event_i |=> !service_status_byte_o[`SRP_BIT_ERR] && !s.armed;
  endproperty
  a_sv_zero: assert property (p_sv_zero) else $error("Zero enable left state");

  property p_abort;
    ce_i && abort_i && !error_event_i && !fire && !file_last_read_i
      |=> service_status_byte_o[`SRP_BIT_ERR] == 1'b0
          && service_status_byte_o[`SRP_BIT_FILE] == 1'b0 && !srq_oe_o && !s.armed;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort did not clear");

  property p_spoll;
    ce_i && sp && !pp |=> dio_oe_o == 8'hFF && dio_o == service_status_byte_o;
  endproperty
  a_spoll: assert property (p_spoll) else $error("Serial poll byte wrong");

  property p_pp_off;
    ce_i && pp && s.pp_line == 4'h0 |=> dio_oe_o == 8'h00;
  endproperty
  a_pp_off: assert property (p_pp_off) else $error("Disabled poll line driven");

  property p_pp_resp;
    ce_i && pp && s.pp_line != 4'h0 && s.pp_req == s.sense
      |=> dio_oe_o == srp_line_dec($past(s.pp_line)) && $onehot(dio_oe_o);
  endproperty
  a_pp_resp: assert property (p_pp_resp) else $error("Poll response line wrong");

  property p_pp_keep;
    ce_i && fire && !poll_line_select_command_i.vld && !init_i |=> s.pp_line == $past(s.pp_line);
  endproperty
  a_pp_keep: assert property (p_pp_keep) else $error("Poll line lost on request");

  property p_srq_hold;
    srq_oe_o && !(ce_i && (rel || event_enable_command_i.vld || abort_i || init_i)) |=> srq_oe_o;
  endproperty
  a_srq_hold: assert property (p_srq_hold) else $error("SRQ dropped before poll");

  property p_srq_release;
    ce_i && rel && !fire |=> !srq_oe_o;
  endproperty
  a_srq_release: assert property (p_srq_release) else $error("SRQ kept after poll");

  property p_eof_full;
    ce_i && reading_stored_i && !file_clear_i && !abort_i && !init_i
      && (s.cnt + 7'h01) == s.store |=> service_status_byte_o[`SRP_BIT_FILE];
  endproperty
  a_eof_full: assert property (p_eof_full) else $error("Store full without end of file");

  // Scenarios
  c_srq: cover property ($rose(srq_oe_o));
  c_spoll_done: cover property (ce_i && rel);
  c_pp_resp: cover property (pp && $rose(|dio_oe_o));
  c_sv_fire: cover property (ce_i && fire && event_enable_command_i.vld);
endmodule : srp_service_poll
`default_nettype wire

// ==== src/srp_params.svh ====
// Purpose: Constants for the service request and poll block
// Assumes: Included by its bare name where needed
// Notes: Bit positions follow the status byte weights
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH
// Status byte bit positions (weight 2**n)
`define SRP_BIT_ERR 0
`define SRP_BIT_MEAS 1
`define SRP_BIT_SWEEP 2
`define SRP_BIT_PLOT 3
`define SRP_BIT_FILE 4
`define SRP_BIT_PROG 5
`define SRP_BIT_RQS 6
`define SRP_BIT_DRDY 7
// Reset values
`define SRP_STB_RST 8'h00
`define SRP_MASK_RST 8'h00
`define SRP_LINE_RST 4'h0
`define SRP_SENSE_RST 1'b1
`define SRP_STORE_RST 7'h63
`define SRP_TERM_RST 2'h0
`define SRP_SEP_RST 1'b0
// Poll line range and drive values
`define SRP_LINE_OFF 4'h0
`define SRP_LINE_MAX 4'h8
`define SRP_DIO_ALL 8'hFF
// Terminator selection: bit 0 adds EOI, bit 1 drops LF
`define SRP_TERM_EOI 0
`define SRP_TERM_CRONLY 1
`define SRP_SEP_COMMA 1'b0
`define SRP_SEP_TERM 1'b1
// Characters
`define SRP_CHR_CR 8'h0D
`define SRP_CHR_LF 8'h0A
`define SRP_CHR_COMMA 8'h2C
`endif

// ==== src/srp_pkg.sv ====
// Purpose: Types shared by the service request and poll block
// Assumes: Constants live in srp_params.svh
// Notes: Each module keeps its whole state in one struct here
package srp_pkg;
  // Live instrument conditions
  typedef struct packed {
    logic data_ready;
    logic end_program;
    logic end_plot;
    logic end_sweep;
    logic end_measure;
  } srp_cond_t;
  // Command strobes with values
  typedef struct packed { logic vld; logic [7:0] val; } srp_cmd8_t;
  typedef struct packed { logic vld; logic [6:0] val; } srp_cmd7_t;
  typedef struct packed { logic vld; logic [3:0] val; } srp_cmd4_t;
  typedef struct packed { logic vld; logic val; } srp_cmd1_t;
  typedef struct packed { logic vld; logic [1:0] term; logic sep; } srp_fmt_cmd_t;
  // Terminator sequencer and synchroniser
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_LAST} srp_seq_t;
  typedef struct packed {
    srp_seq_t st;
    logic [7:0] byte_q;
    logic eoi;
    logic eoi_end;
  } srp_term_st_t;
  typedef struct packed { logic [1:0] meta; logic [1:0] q; } srp_sync_st_t;
  // Main block state
  typedef struct packed {
    logic [7:0] mask;
    logic armed;
    logic srq;
    logic rqs;
    logic err;
    logic eof;
    logic [6:0] cnt;
    logic [6:0] store;
    logic [7:0] stb;
    logic sp_prev;
    logic polled;
    logic [3:0] pp_line;
    logic sense;
    logic pp_req;
    logic [1:0] term;
    logic sep;
    logic [7:0] dio;
    logic [7:0] dio_oe;
  } srp_state_t;
endpackage : srp_pkg

// ==== src/srp_sync2.sv ====
// Purpose: Two-stage synchroniser for the poll state pins
// Assumes: Pins are asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module srp_sync2 (
  input wire logic clk_i,       // Clock
  input wire logic rst_i,       // Sync reset
  input wire logic ce_i,        // Clock enable
  input wire logic [1:0] d_i,   // Async inputs
  output logic [1:0] q_o        // Synchronised
);
  import srp_pkg::*;
  srp_sync_st_t s;
  srp_sync_st_t nxt;

  // Shift through two stages
  always_comb begin
    nxt = s;
    nxt.meta = d_i;
    nxt.q = s.meta;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= nxt;
    end
  end

  assign q_o = s.q;
endmodule : srp_sync2
`default_nettype wire

// ==== src/srp_line_term.sv ====
// Purpose: Emits separator or terminator characters of a bus line
// Assumes: Config and requests from logic on clk_i
// Notes: EOI only rides on a terminator, never on a separator
`timescale 1ns/1ns
`default_nettype none
`include "srp_params.svh"
module srp_line_term (
  input wire logic clk_i,        // Clock
  input wire logic rst_i,        // Sync reset
  input wire logic ce_i,         // Clock enable
  input wire logic [1:0] term_i, // Terminator select
  input wire logic sep_i,        // Separator select
  input wire logic req_valid_i,  // Request valid
  input wire logic req_term_i,   // 1 terminator, 0 separator
  output logic req_ready_o,      // Request taken
  output logic tx_valid_o,       // Byte valid
  input wire logic tx_ready_i,   // Byte taken
  output logic [7:0] tx_byte_o,  // Byte
  output logic tx_eoi_o          // EOI with byte
);
  import srp_pkg::*;
  srp_term_st_t s;
  srp_term_st_t nxt;

  // Character sequencing
  always_comb begin
    nxt = s;
    case (s.st)
      SEQ_IDLE: begin
        if (req_valid_i) begin
          if (!req_term_i && sep_i == `SRP_SEP_COMMA) begin
            nxt.byte_q = `SRP_CHR_COMMA;
            nxt.eoi = 1'b0;
            nxt.st = SEQ_LAST;
          end else begin
            nxt.byte_q = `SRP_CHR_CR;
            nxt.eoi_end = req_term_i && term_i[`SRP_TERM_EOI];
            if (term_i[`SRP_TERM_CRONLY]) begin
              nxt.eoi = nxt.eoi_end;
              nxt.st = SEQ_LAST;
            end else begin
              nxt.eoi = 1'b0;
              nxt.st = SEQ_FIRST;
            end
          end
        end
      end
      SEQ_FIRST: begin
        if (tx_ready_i) begin
          nxt.byte_q = `SRP_CHR_LF;
          nxt.eoi = s.eoi_end;
          nxt.st = SEQ_LAST;
        end
      end
      SEQ_LAST: begin
        if (tx_ready_i) begin
          nxt.st = SEQ_IDLE;
        end
      end
      default: begin
        nxt.st = SEQ_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= nxt;
    end
  end

  assign req_ready_o = (s.st == SEQ_IDLE);
  assign tx_valid_o = (s.st != SEQ_IDLE);
  assign tx_byte_o = s.byte_q;
  assign tx_eoi_o = s.eoi;

  // Checks
  property p_lf_after_cr;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && s.st == SEQ_FIRST && tx_ready_i |=> tx_valid_o && tx_byte_o == `SRP_CHR_LF;
  endproperty
  a_lf_after_cr: assert property (p_lf_after_cr) else $error("LF missing after CR");
  property p_comma;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && req_valid_i && req_ready_o && !req_term_i && sep_i == `SRP_SEP_COMMA
      |=> tx_byte_o == `SRP_CHR_COMMA && !tx_eoi_o;
  endproperty
  a_comma: assert property (p_comma) else $error("Separator not comma");
endmodule : srp_line_term
`default_nettype wire

// ==== dv/srp_ctrl_model.sv ====
// Purpose: Behavioural bus controller facing the service request and poll block
// Assumes: Poll pins and character acceptance change on the falling edge
// Notes: Released data lines read back as false, as on a pulled-up bus
`timescale 1ns/1ns
`default_nettype none
module srp_ctrl_model (
  input wire logic clk_i,         // Clock
  input wire logic [7:0] dio_i,   // Device data line levels
  input wire logic [7:0] dio_oe_i, // Device data line drives
  input wire logic tx_valid_i,    // Char offered
  input wire logic [7:0] tx_byte_i, // Char
  input wire logic tx_eoi_i,      // EOI with char
  input wire logic slow_i,        // Accept every other cycle
  output logic spoll_o,           // Serial poll pin
  output logic ppoll_o,           // Parallel poll pin
  output logic tx_ready_o         // Char taken
);
  logic [8:0] rx_q[$];
  logic toggle;
  initial begin
    spoll_o = 1'b0;
    ppoll_o = 1'b0;
    tx_ready_o = 1'b0;
    toggle = 1'b0;
  end
  // Acceptance pacing, prompt or stalling
  always @(negedge clk_i) begin
    toggle <= ~toggle;
    tx_ready_o <= ~slow_i | toggle;
  end
  // Record each char taken, with its EOI
  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) begin
      rx_q.push_back({tx_eoi_i, tx_byte_i});
    end
  end
  // One poll cycle; returns the true lines seen
  task automatic poll(input logic serial, output logic [7:0] lines);
    @(negedge clk_i);
    spoll_o = serial;
    ppoll_o = ~serial;
    repeat (4) @(negedge clk_i);
    lines = dio_i & dio_oe_i;
    spoll_o = 1'b0; // Poll done, device may drop SRQ
    ppoll_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : poll
endmodule : srp_ctrl_model
`default_nettype wire

// ==== dv/srp_service_poll_tb.sv ====
// Purpose: Self-checking bench for the service request and poll block
// Assumes: Controller model drives poll pins and takes characters
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
`include "srp_params.svh"
module srp_service_poll_tb;
  import srp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  srp_cond_t cond = '0;
  logic err_ev = 1'b0, stored = 1'b0, last_rd = 1'b0, fclr = 1'b0, abort = 1'b0, init = 1'b0;
  srp_cmd8_t en_cmd = '0;
  srp_cmd4_t pp_cmd = '0;
  srp_cmd1_t ps_cmd = '0;
  srp_fmt_cmd_t fmt_cmd = '0;
  srp_cmd7_t st_cmd = '0;
  logic lr_vld = 1'b0, lr_term = 1'b0, slow = 1'b0, ce = 1'b1;
  wire logic spoll, ppoll, lr_rdy, tx_vld, tx_rdy, tx_eoi, srq_oe, srq_lvl;
  wire logic [7:0] tx_byte, stb, dio, dio_oe;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] got;
  logic [8:0] exp_q[$];
  localparam logic [7:0] live_wt [5] = '{8'h02, 8'h04, 8'h08, 8'h20, 8'h80};
  // Clock, 50 ns period
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  srp_service_poll u_srp_service_poll (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cond_i(cond), .error_event_i(err_ev),
    .reading_stored_i(stored), .file_last_read_i(last_rd), .file_clear_i(fclr),
    .abort_i(abort), .init_i(init), .event_enable_command_i(en_cmd),
    .poll_line_select_command_i(pp_cmd), .poll_sense_command_i(ps_cmd),
    .store_size_cmd_i(st_cmd), .format_cmd_i(fmt_cmd), .spoll_active_i(spoll),
    .ppoll_active_i(ppoll), .line_req_valid_i(lr_vld), .line_req_term_i(lr_term),
    .line_req_ready_o(lr_rdy), .tx_valid_o(tx_vld), .tx_ready_i(tx_rdy), .tx_byte_o(tx_byte),
    .tx_eoi_o(tx_eoi), .service_status_byte_o(stb), .srq_o(srq_lvl), .srq_oe_o(srq_oe),
    .dio_o(dio), .dio_oe_o(dio_oe));
  srp_ctrl_model u_srp_ctrl_model (
    .clk_i(clk_i), .dio_i(dio), .dio_oe_i(dio_oe), .tx_valid_i(tx_vld), .tx_byte_i(tx_byte),
    .tx_eoi_i(tx_eoi), .slow_i(slow), .spoll_o(spoll), .ppoll_o(ppoll), .tx_ready_o(tx_rdy));
  // Advance n falling edges, dropping one-cycle pulses
  task automatic step(input int n = 1);
    repeat (n) begin
      @(negedge clk_i);
      en_cmd.vld = 1'b0;
      pp_cmd.vld = 1'b0;
      ps_cmd.vld = 1'b0;
      fmt_cmd.vld = 1'b0;
      st_cmd.vld = 1'b0;
      err_ev = 1'b0;
      stored = 1'b0;
      last_rd = 1'b0;
      fclr = 1'b0;
      abort = 1'b0;
      init = 1'b0;
    end
  endtask : step
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk1
  // Line end request, raised for one cycle once the sequencer is idle
  task automatic line_req(input logic term);
    int k;
    k = 0;
    while (lr_rdy !== 1'b1 && k < 50) begin
      step();
      k++;
    end
    lr_vld = 1'b1;
    lr_term = term;
    step();
    lr_vld = 1'b0;
  endtask : line_req
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    step(5);
    rst_i = 1'b0;
    step();
    chk8("stb", 8'h00, stb);
    chk1("srq_oe", 1'b0, srq_oe);
    chk1("line ready", 1'b1, lr_rdy);
    // Clock enable low freezes the status byte
    ce = 1'b0;
    cond.end_measure = 1'b1;
    step(2);
    chk8("frozen stb", 8'h00, stb);
    ce = 1'b1;
    // Live conditions, one weight each
    for (int i = 0; i < 5; i++) begin
      cond = 5'(1 << i);
      step(2);
      chk8("live bit", live_wt[i], stb);
    end
    cond = '0;
    step(2);
    chk8("live clear", 8'h00, stb);
    err_ev = 1'b1;
    step(2);
    chk8("error set", 8'h01, stb);
    en_cmd = '{1'b1, 8'h00};
    step(2);
    chk8("error cleared", 8'h00, stb);
    // Single enabled event raises SRQ once
    en_cmd = '{1'b1, 8'h08}; // One event only
    step(2);
    chk1("srq idle", 1'b0, srq_oe);
    cond.end_plot = 1'b1;
    step(3);
    chk1("srq", 1'b1, srq_oe);
    chk8("rqs", 8'h48, stb);
    chk1("srq level", 1'b0, srq_lvl);
    u_srp_ctrl_model.poll(1'b1, got);
    chk8("serial poll", 8'h48, got);
    chk1("srq released", 1'b0, srq_oe);
    cond.end_plot = 1'b0;
    step(2);
    cond.end_plot = 1'b1;
    step(3);
    chk1("srq disarmed", 1'b0, srq_oe);
    abort = 1'b1;
    step(2);
    chk8("abort", 8'h08, stb);
    cond = '0;
    // Parallel poll on line 3
    en_cmd = '{1'b1, 8'h04};
    pp_cmd = '{1'b1, 4'h3};
    step(2);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll idle", 8'h00, got);
    cond.end_sweep = 1'b1;
    step(3);
    pp_cmd = '{1'b1, 4'h9};
    step(2);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll req", 8'h04, got);
    ps_cmd = '{1'b1, 1'b0};
    step(2);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll sense0 req", 8'h00, got);
    en_cmd = '{1'b1, 8'h04};
    step(2);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll sense0 clr", 8'h04, got);
    ps_cmd = '{1'b1, 1'b1};
    cond.end_sweep = 1'b0;
    step(2);
    cond.end_sweep = 1'b1;
    step(3);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll again", 8'h04, got);
    pp_cmd = '{1'b1, 4'h0};
    step(2);
    u_srp_ctrl_model.poll(1'b0, got);
    chk8("ppoll off", 8'h00, got);
    // End of file at default store size, then on last read
    cond = '0;
    en_cmd = '{1'b1, 8'h00};
    step(2);
    for (int i = 1; i <= 99; i++) begin
      stored = 1'b1;
      step(2);
      if (i >= 98) chk8("file full", (i == 99) ? 8'h10 : 8'h00, stb & 8'h10);
    end
    fclr = 1'b1;
    step(2);
    chk8("file clear", 8'h00, stb & 8'h10);
    last_rd = 1'b1;
    step(2);
    chk8("last read", 8'h10, stb & 8'h10);
    // Configured store size of three readings
    st_cmd = '{1'b1, 7'h03};
    fclr = 1'b1;
    step(2);
    for (int i = 1; i <= 3; i++) begin
      stored = 1'b1;
      step(2);
      chk8("file size", (i == 3) ? 8'h10 : 8'h00, stb & 8'h10);
    end
    init = 1'b1;
    step(2);
    chk8("init", 8'h00, stb);
    // Every terminator, each separator mode, fast and stalling taker
    for (int t = 0; t < 4; t++) begin
      fmt_cmd = '{1'b1, 2'(t), t[0]};
      slow = t[1];
      step();
      u_srp_ctrl_model.rx_q.delete();
      line_req(1'b1);
      line_req(1'b0);
      step(20);
      exp_q.delete();
      exp_q.push_back({t[0] & t[1], `SRP_CHR_CR});
      if (!t[1]) exp_q.push_back({t[0], `SRP_CHR_LF});
      if (!t[0]) exp_q.push_back({1'b0, `SRP_CHR_COMMA});
      if (t[0]) exp_q.push_back({1'b0, `SRP_CHR_CR});
      if (t[0] && !t[1]) exp_q.push_back({1'b0, `SRP_CHR_LF});
      chk8("char count", 8'(exp_q.size()), 8'(u_srp_ctrl_model.rx_q.size()));
      foreach (exp_q[i]) begin
        if (i < u_srp_ctrl_model.rx_q.size()) begin
          chk8("char", exp_q[i][7:0], u_srp_ctrl_model.rx_q[i][7:0]);
          chk1("eoi", exp_q[i][8], u_srp_ctrl_model.rx_q[i][8]);
        end
      end
    end
    stop_test();
  end
endmodule : srp_service_poll_tb
`default_nettype wire
